// ---- rtl/dpio_map.vh ----
// Register map and field constants of the pad configuration bank
// Functional notes
// (R1) Top two bits select address/command slew
// (R2) Low thirty bits read-only fixed pattern
// (R3) Data slew field, same coding, resets fast
// (R4) Receiver countdown offset, reset four
// (R5) Driver countdown offset, reset four
// (R6) Dynamic receiver powerdown unless static set
// (R7) Dynamic driver powerdown unless static set
// (R8) Unused bit pad mode: SSTL or CMOS
// (R9) Unused bit receiver powerdown, set after reset
// (R10) Unused bit driver powerdown, set after reset
// (R11) Unused bit termination, clear after reset
// (R12) Top lane unused count masks upper bits
// (R13) Complement strobe resistor, reset 0xC
// (R14) Resistor top bit pull direction, low value
// (R15) Reserved writes ignored, fields read back
`ifndef DPIO_MAP_VH
`define DPIO_MAP_VH
// ***********************************************
// Offsets
// ***********************************************
`define DPIO_OFS_AC 12'h000
`define DPIO_OFS_DX 12'h004
// ***********************************************
// Reset values
// ***********************************************
`define DPIO_AC_RSV_VAL 30'h33C03812
`define DPIO_AC_SLEW_RST 2'h0
// Offsets 4/4, unused rx/tx powerdown set, complement strobe 0xC, true strobe 0x4
`define DPIO_DX_RST 32'h44181880
`define DPIO_DX_WMASK 32'hFFFFFFE0
// ***********************************************
// Field positions
// ***********************************************
`define DPIO_AC_SLEW_HI 31
`define DPIO_AC_SLEW_LO 30
`define DPIO_RXCDO_HI 31
`define DPIO_RXCDO_LO 28
`define DPIO_TXCDO_HI 27
`define DPIO_TXCDO_LO 24
`define DPIO_DYNRX_BIT 23
`define DPIO_DYNTX_BIT 22
`define DPIO_UIOM_BIT 21
`define DPIO_UPDR_BIT 20
`define DPIO_UPDD_BIT 19
`define DPIO_UODT_BIT 18
`define DPIO_MSBU_HI 17
`define DPIO_MSBU_LO 15
`define DPIO_DSLEW_HI 14
`define DPIO_DSLEW_LO 13
`define DPIO_SNRES_HI 12
`define DPIO_SNRES_LO 9
`define DPIO_LANE_BITS 8
`endif

// ---- rtl/dpio_regs.v ----
// Pad configuration register bank with APB slave and pad control outputs
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "dpio_map.vh"
`default_nettype none
module dpio_regs (
   // APB
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output wire pslverr,
   // Per-lane static powerdown from lane configuration
   input wire lane_static_rx_pd,
   input wire lane_static_tx_pd,
   // Address/command pads
   output reg [1:0] addr_cmd_slew_sel,
   // Data pads
   output reg [1:0] data_pad_slew_sel,
   output reg [3:0] dyn_rx_pd_countdown_offset,
   output reg [3:0] dyn_tx_pd_countdown_offset,
   output reg dyn_rx_powerdown_active,
   output reg dyn_tx_powerdown_active,
   output reg unused_bit_pad_mode,
   output reg unused_bit_rx_powerdown,
   output reg unused_bit_tx_powerdown,
   output reg unused_bit_termination_en,
   output wire [7:0] top_lane_valid_bits,
   output reg [3:0] strobe_n_resistor_sel,
   output reg strobe_n_pullup,
   output reg [2:0] strobe_n_res_value,
   output reg strobe_n_res_open
);
   // ***********************************************
   // Register storage
   // ***********************************************
   reg [1:0] ac_slew_q;
   reg [31:0] dx_q;
   wire [31:0] dx_d;
   wire wr_en;
   wire hit_ac;
   wire hit_dx;
   // Zero wait states; every access completes on its access cycle
   assign pready = 1'b1;
   assign hit_ac = (paddr == `DPIO_OFS_AC);
   assign hit_dx = (paddr == `DPIO_OFS_DX);
   // Unmapped addresses answer with an error rather than silent zero
   assign pslverr = psel & penable & ~(hit_ac | hit_dx);
   assign wr_en = psel & penable & pwrite;
   // Low bits belong to the next field group and are held at their reset value
   assign dx_d = (pwdata & `DPIO_DX_WMASK) | (dx_q & ~`DPIO_DX_WMASK); // see (R15)
   // Writes land only on the access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ac_slew_q <= `DPIO_AC_SLEW_RST;
         dx_q <= `DPIO_DX_RST; // see (R4) see (R5) see (R9) see (R10) see (R13)
      end else begin
         if (wr_en && hit_ac) begin
            ac_slew_q <= pwdata[`DPIO_AC_SLEW_HI:`DPIO_AC_SLEW_LO]; // see (R1)
         end
         if (wr_en && hit_dx) begin
            dx_q <= dx_d;
         end
      end
   end
   // ***********************************************
   // Read path
   // ***********************************************
   // Registered read data, captured in the setup cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         if (hit_ac) begin
            prdata <= {ac_slew_q, `DPIO_AC_RSV_VAL}; // see (R2) see (R15)
         end else if (hit_dx) begin
            prdata <= dx_q; // see (R15)
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end
   // ***********************************************
   // Pad controls
   // ***********************************************
   // Registered decode so pad controls never glitch
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_cmd_slew_sel <= 2'h0;
         data_pad_slew_sel <= 2'h0;
         dyn_rx_pd_countdown_offset <= 4'h4;
         dyn_tx_pd_countdown_offset <= 4'h4;
         dyn_rx_powerdown_active <= 1'b0;
         dyn_tx_powerdown_active <= 1'b0;
         unused_bit_pad_mode <= 1'b0;
         unused_bit_rx_powerdown <= 1'b1;
         unused_bit_tx_powerdown <= 1'b1;
         unused_bit_termination_en <= 1'b0;
         strobe_n_resistor_sel <= 4'hC;
         strobe_n_pullup <= 1'b1;
         strobe_n_res_value <= 3'h4;
         strobe_n_res_open <= 1'b0;
      end else begin
         addr_cmd_slew_sel <= ac_slew_q; // see (R1)
         data_pad_slew_sel <= dx_q[`DPIO_DSLEW_HI:`DPIO_DSLEW_LO]; // see (R3)
         dyn_rx_pd_countdown_offset <= dx_q[`DPIO_RXCDO_HI:`DPIO_RXCDO_LO]; // see (R4)
         dyn_tx_pd_countdown_offset <= dx_q[`DPIO_TXCDO_HI:`DPIO_TXCDO_LO]; // see (R5)
         // Static powerdown overrides; the common static bits stay clear here
         dyn_rx_powerdown_active <= dx_q[`DPIO_DYNRX_BIT] & ~lane_static_rx_pd; // see (R6)
         dyn_tx_powerdown_active <= dx_q[`DPIO_DYNTX_BIT] & ~lane_static_tx_pd; // see (R7)
         unused_bit_pad_mode <= dx_q[`DPIO_UIOM_BIT]; // see (R8)
         unused_bit_rx_powerdown <= dx_q[`DPIO_UPDR_BIT]; // see (R9)
         unused_bit_tx_powerdown <= dx_q[`DPIO_UPDD_BIT]; // see (R10)
         unused_bit_termination_en <= dx_q[`DPIO_UODT_BIT]; // see (R11)
         strobe_n_resistor_sel <= dx_q[`DPIO_SNRES_HI:`DPIO_SNRES_LO]; // see (R13)
         strobe_n_pullup <= dx_q[`DPIO_SNRES_HI]; // see (R14)
         strobe_n_res_value <= dx_q[`DPIO_SNRES_HI-1:`DPIO_SNRES_LO]; // see (R14)
         strobe_n_res_open <= (dx_q[`DPIO_SNRES_HI-1:`DPIO_SNRES_LO] == 3'h0); // see (R14)
      end
   end
   // Top lane valid bits
   dpio_valid_mask #(
      .LANE_BITS(`DPIO_LANE_BITS)
   ) u_mask (
      .pclk(pclk),
      .presetn(presetn),
      .unused_cnt(dx_q[`DPIO_MSBU_HI:`DPIO_MSBU_LO]), // see (R12)
      .valid_q(top_lane_valid_bits)
   );
endmodule
`default_nettype wire

// ---- rtl/dpio_valid_mask.v ----
// Valid-bit mask of the top data byte lane from its unused count
`timescale 1ns/1ps
`default_nettype none
module dpio_valid_mask #(
   parameter LANE_BITS = 8
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Count of unused top bits
   input wire [2:0] unused_cnt,
   // Registered mask, one per bit
   output reg [LANE_BITS-1:0] valid_q
);
   genvar gi;
   // Bit i is valid while i < LANE_BITS - count
   generate
      for (gi = 0; gi < LANE_BITS; gi = gi + 1) begin : g_bit
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               valid_q[gi] <= 1'b1;
            end else begin
               // Sum instead of difference, so a large count never wraps negative
               valid_q[gi] <= (({29'h0, unused_cnt} + gi) < LANE_BITS); // see (R12)
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ---- verification/dpio_monitor.sv ----
// Checker of pad outputs and APB reads of the pad configuration bank
`timescale 1ns/1ps
`default_nettype none
module dpio_monitor (
   input wire pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire [11:0] paddr,
   input wire [31:0] pwdata, prdata,
   input wire lane_static_rx_pd, lane_static_tx_pd,
   input wire [1:0] addr_cmd_slew_sel, data_pad_slew_sel,
   input wire [3:0] dyn_rx_pd_countdown_offset, dyn_tx_pd_countdown_offset,
   input wire dyn_rx_powerdown_active, dyn_tx_powerdown_active,
   input wire [7:0] top_lane_valid_bits,
   input wire [3:0] strobe_n_resistor_sel,
   input wire strobe_n_pullup, strobe_n_res_open,
   input wire [2:0] strobe_n_res_value
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Outputs trail the stored word by one register stage
   wire w_ac = psel && penable && pwrite && paddr == 12'h000;
   wire w_dx = psel && penable && pwrite && paddr == 12'h004;
   property p_acslew;
      w_ac |-> ##2 addr_cmd_slew_sel == $past(pwdata[31:30], 2);
   endproperty
   a_acslew: assert property (p_acslew) else $error("ac slew wrong");
   property p_rsv;
      psel && !penable && !pwrite && paddr == 12'h000 |=> prdata[29:0] == 30'h33C03812;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits wrong");
   property p_dslew;
      w_dx |-> ##2 data_pad_slew_sel == $past(pwdata[14:13], 2);
   endproperty
   a_dslew: assert property (p_dslew) else $error("data slew wrong");
   property p_ofs;
      w_dx |-> ##2
         {dyn_rx_pd_countdown_offset, dyn_tx_pd_countdown_offset} == $past(pwdata[31:24], 2);
   endproperty
   a_ofs: assert property (p_ofs) else $error("offsets wrong");
   property p_dynrx;
      dyn_rx_powerdown_active |-> !$past(lane_static_rx_pd);
   endproperty
   a_dynrx: assert property (p_dynrx) else $error("rx pd not gated");
   property p_dyntx;
      dyn_tx_powerdown_active |-> !$past(lane_static_tx_pd);
   endproperty
   a_dyntx: assert property (p_dyntx) else $error("tx pd not gated");
   property p_valid;
      w_dx |-> ##2 top_lane_valid_bits == (8'hFF >> $past(pwdata[17:15], 2));
   endproperty
   a_valid: assert property (p_valid) else $error("valid mask wrong");
   property p_res;
      strobe_n_pullup == strobe_n_resistor_sel[3]
         && strobe_n_res_value == strobe_n_resistor_sel[2:0]
         && strobe_n_res_open == (strobe_n_res_value == 3'h0);
   endproperty
   a_res: assert property (p_res) else $error("resistor decode wrong");
   // The bank never stretches an access, so a waiting master cannot hang on it
   property p_ready;
      psel && penable |-> pready;
   endproperty
   a_ready: assert property (p_ready) else $error("access stalled");
endmodule
bind dpio_regs dpio_monitor u_mon (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .lane_static_rx_pd(lane_static_rx_pd), .lane_static_tx_pd(lane_static_tx_pd),
   .addr_cmd_slew_sel(addr_cmd_slew_sel), .data_pad_slew_sel(data_pad_slew_sel),
   .dyn_rx_pd_countdown_offset(dyn_rx_pd_countdown_offset),
   .dyn_tx_pd_countdown_offset(dyn_tx_pd_countdown_offset),
   .dyn_rx_powerdown_active(dyn_rx_powerdown_active),
   .dyn_tx_powerdown_active(dyn_tx_powerdown_active),
   .top_lane_valid_bits(top_lane_valid_bits),
   .strobe_n_resistor_sel(strobe_n_resistor_sel),
   .strobe_n_pullup(strobe_n_pullup), .strobe_n_res_open(strobe_n_res_open),
   .strobe_n_res_value(strobe_n_res_value)
);
`default_nettype wire

// ---- verification/tb_ddr_phy_io_config_regs.sv ----
// Register bank testbench: APB reads and writes with pad output checks
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
   num_checks++; \
   if ((a) !== (b)) begin \
      n_fail++; \
      $display("Error %0t: got %h exp %h", $time, (a), (b)); \
   end \
end
module tb_ddr_phy_io_config_regs;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
   logic lane_static_rx_pd = 0, lane_static_tx_pd = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, r, d;
   wire pready, pslverr, dyn_rx_powerdown_active, dyn_tx_powerdown_active, unused_bit_pad_mode;
   wire unused_bit_rx_powerdown, unused_bit_tx_powerdown, unused_bit_termination_en;
   wire strobe_n_pullup, strobe_n_res_open;
   wire [31:0] prdata;
   wire [1:0] addr_cmd_slew_sel, data_pad_slew_sel;
   wire [3:0] dyn_rx_pd_countdown_offset, dyn_tx_pd_countdown_offset, strobe_n_resistor_sel;
   wire [7:0] top_lane_valid_bits;
   wire [2:0] strobe_n_res_value;
   int n_fail = 0, num_checks = 0, cyc = 0;
   dpio_regs dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .lane_static_rx_pd(lane_static_rx_pd), .lane_static_tx_pd(lane_static_tx_pd),
      .addr_cmd_slew_sel(addr_cmd_slew_sel), .data_pad_slew_sel(data_pad_slew_sel),
      .dyn_rx_pd_countdown_offset(dyn_rx_pd_countdown_offset),
      .dyn_tx_pd_countdown_offset(dyn_tx_pd_countdown_offset),
      .dyn_rx_powerdown_active(dyn_rx_powerdown_active),
      .dyn_tx_powerdown_active(dyn_tx_powerdown_active),
      .unused_bit_pad_mode(unused_bit_pad_mode),
      .unused_bit_rx_powerdown(unused_bit_rx_powerdown),
      .unused_bit_tx_powerdown(unused_bit_tx_powerdown),
      .unused_bit_termination_en(unused_bit_termination_en),
      .top_lane_valid_bits(top_lane_valid_bits),
      .strobe_n_resistor_sel(strobe_n_resistor_sel), .strobe_n_pullup(strobe_n_pullup),
      .strobe_n_res_value(strobe_n_res_value), .strobe_n_res_open(strobe_n_res_open)
   );
   // Clock and hang guard
   initial forever #10 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 2000) begin n_fail++; conclude; end
   end
   task conclude;
      $display("Checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // One APB transfer; waits on pready, never on a fixed count
   task io(input logic w, input logic [11:0] a, input logic [31:0] v);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= v;
      @(posedge pclk) penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata; e = pslverr;
      psel <= 0; penable <= 0;
      @(posedge pclk);
   endtask
   // Pad outputs against the common word v, then realign to an edge
   task pads(input logic [31:0] v);
      `CHK(data_pad_slew_sel, v[14:13])
      `CHK(dyn_rx_pd_countdown_offset, v[31:28])
      `CHK(dyn_tx_pd_countdown_offset, v[27:24])
      `CHK(dyn_rx_powerdown_active, v[23] & ~lane_static_rx_pd)
      `CHK(dyn_tx_powerdown_active, v[22] & ~lane_static_tx_pd)
      `CHK(unused_bit_pad_mode, v[21])
      `CHK(unused_bit_rx_powerdown, v[20])
      `CHK(unused_bit_tx_powerdown, v[19])
      `CHK(unused_bit_termination_en, v[18])
      `CHK(top_lane_valid_bits, 8'hFF >> v[17:15])
      `CHK(strobe_n_resistor_sel, v[12:9])
      `CHK({strobe_n_pullup, strobe_n_res_value}, v[12:9])
      `CHK(strobe_n_res_open, v[11:9] == 3'h0)
      @(posedge pclk);
   endtask
   // Reset values, then a nibble sweep that reaches every field code
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      io(0, 12'h000, 0); `CHK(r, 32'h33C03812)
      io(0, 12'h004, 0); `CHK(r, 32'h44181880)
      #1 pads(32'h44181880);
      for (int i = 0; i < 16; i++) begin
         d = 32'h11111111 * i[3:0];
         lane_static_rx_pd <= i[0];
         lane_static_tx_pd <= i[1];
         io(1, 12'h000, d);
         io(1, 12'h004, d);
         io(0, 12'h000, 0); `CHK(r, {d[31:30], 30'h33C03812})
         io(0, 12'h004, 0); `CHK(r, d & 32'hFFFFFFE0)
         #1 `CHK(addr_cmd_slew_sel, d[31:30])
         pads(d);
      end
      // Unmapped place refuses and leaves the bank alone
      io(1, 12'h008, 32'h0); `CHK(e, 1'b1)
      io(0, 12'h008, 0); `CHK({e, r}, 33'h100000000)
      io(0, 12'h004, 0); `CHK(r, 32'hFFFFFFE0)
      conclude;
   end
endmodule
`default_nettype wire
